//--- rtl/dcps_defs.svh
/*
  Timing counts, command codes and bit positions for the clock-enable
  power-state block. Assumes a 40 MHz core clock (25 ns period).
*/
`ifndef DCPS_DEFS_SVH
`define DCPS_DEFS_SVH

// Clock period in picoseconds
`define DCPS_CLK_PS          25000
// Minimum clock-enable pulse, in picoseconds
`define DCPS_CKE_MIN_PS      5000
// Self-refresh exit time, in picoseconds
`define DCPS_XS_PS           270000
// DLL lock time after self-refresh exit, in picoseconds
`define DCPS_XSDLL_PS        15000000
// Burst length in clock cycles
`define DCPS_BURST_CYC       8'h04
// Row precharge time in clock cycles
`define DCPS_PRE_CYC         8'h03
// Refresh cycle time in clock cycles
`define DCPS_REF_CYC         8'h0B
// Power-down exit time in clock cycles
`define DCPS_XP_CYC          8'h02
// Derived counts, rounded up; the self-refresh exit count is held to at least one cycle
`define DCPS_XS_CYC   (((`DCPS_XS_PS + `DCPS_CLK_PS - 1) / `DCPS_CLK_PS) < 1 ? 1 : \
                       ((`DCPS_XS_PS + `DCPS_CLK_PS - 1) / `DCPS_CLK_PS))
`define DCPS_XSDLL_CYC (((`DCPS_XSDLL_PS + `DCPS_CLK_PS - 1) / `DCPS_CLK_PS))

// Command pin pattern {act_n, ras_n, cas_n, we_n}; activate is act_n low
`define DCPS_CMD_NOP         4'hF
`define DCPS_PAT_REF         4'h9
`define DCPS_PAT_PRE         4'hA
`define DCPS_PAT_WR          4'hC
`define DCPS_PAT_RD          4'hD
// One-hot state bits that drive status pins directly
`define DCPS_ST_PDOWN_BIT    6
`define DCPS_ST_SREF_BIT     7

`endif

//--- rtl/dcps_pkg.sv
/*
  Types for the clock-enable power-state block.
  Assumes dcps_defs.svh is available on the include path.
*/
package dcps_pkg;

  // Device state, one-hot
  typedef enum logic [7:0] {
    DCPS_IDLE   = 8'h01,
    DCPS_ACTIVE = 8'h02,
    DCPS_READ   = 8'h04,
    DCPS_WRITE  = 8'h08,
    DCPS_PRECH  = 8'h10,
    DCPS_REFR   = 8'h20,
    DCPS_PDOWN  = 8'h40,
    DCPS_SREF   = 8'h80
  } dcps_state_t;

  // Decoded command
  typedef enum logic [2:0] {
    DCPS_C_DES = 3'h0,
    DCPS_C_NOP = 3'h1,
    DCPS_C_ACT = 3'h2,
    DCPS_C_RD  = 3'h3,
    DCPS_C_WR  = 3'h4,
    DCPS_C_PRE = 3'h5,
    DCPS_C_REF = 3'h6,
    DCPS_C_OTH = 3'h7
  } dcps_cmd_t;

endpackage

//--- rtl/dcps_cmd_decode.sv
/*
  Command decoder: turns the sampled command pins into a command code.
  Assumes pins are synchronous to ref_clk and sampled by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcps_defs.svh"

module dcps_cmd_decode
  import dcps_pkg::*;
(
  // Command pins
  input  wire logic       csN,
  input  wire logic       actN,
  input  wire logic       rasN,
  input  wire logic       casN,
  input  wire logic       weN,
  // Decoded command
  output dcps_cmd_t       cmd
);

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  wire logic [3:0] pat = {actN, rasN, casN, weN};

  // Chip select high is deselect; pattern chooses the rest
  always_comb begin
    if (csN)
      cmd = DCPS_C_DES;
    else if (!actN)
      cmd = DCPS_C_ACT;
    else if (pat == `DCPS_CMD_NOP)
      cmd = DCPS_C_NOP;
    else if (pat == `DCPS_PAT_RD)
      cmd = DCPS_C_RD;
    else if (pat == `DCPS_PAT_WR)
      cmd = DCPS_C_WR;
    else if (pat == `DCPS_PAT_PRE)
      cmd = DCPS_C_PRE;
    else if (pat == `DCPS_PAT_REF)
      cmd = DCPS_C_REF;
    else
      cmd = DCPS_C_OTH;
  end

endmodule
`default_nettype wire

//--- rtl/dcps_timer.sv
/*
  Down-counting timer, loaded with a count and reporting when expired.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dcps_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Load
  input  wire logic        load,
  input  wire logic [19:0] loadVal,
  // Status
  output logic             done
);

  // --------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------
  logic [19:0] count_r;

  // Load has priority; otherwise count down to zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      count_r <= 20'h00000;
    else if (load)
      count_r <= loadVal;
    else if (count_r != 20'h00000)
      count_r <= count_r - 20'h00001;
  end

  assign done = (count_r == 20'h00000);

endmodule
`default_nettype wire

//--- rtl/dcps_power_ctrl.sv
/*
  Clock-enable power-state control of a DRAM device: tracks the device
  state from the clock-enable pair and the registered command, and
  reports power-down, self refresh, idle and termination availability.
  Assumes the controller keeps to the legal command and clock-enable
  sequences; all pins are synchronous to ref_clk.
*/
// Notes on behaviour
// - Act on previous, current clock enable, state
// - Self refresh entered only from idle
// - Idle needs banks closed, timers expired
// - Power-down kind depends on open banks
// - No refresh while in power-down
// - Command pins ignored while clock enable stays low
// - Termination ignored; unavailable in self refresh
// - No-operation decoded, does nothing
// - Deselect accepts no new command
// - Deselect leaves running operations unaffected
// - Commands decoded from pins at rising edge
// - Reset is asynchronous only
`timescale 1ns/1ps
`default_nettype none
`include "dcps_defs.svh"

module dcps_power_ctrl
  import dcps_pkg::*;
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  // Command pins
  input  wire logic  cke,
  input  wire logic  csN,
  input  wire logic  actN,
  input  wire logic  rasN,
  input  wire logic  casN,
  input  wire logic  weN,
  input  wire logic  odt,
  // Bank bookkeeping
  input  wire logic  autoPre,
  // Status
  output logic [7:0] devState,
  output logic       inPowerDown,
  output logic       inSelfRefresh,
  output logic       isIdle,
  output logic       banksOpen,
  output logic       refreshBusy,
  output logic       odtEnable,
  output logic       readAllowed
);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  dcps_state_t state_r, state_nxt;
  logic        ckePrev_r;
  logic        banksOpen_r, banksOpen_nxt;
  logic [7:0]  opCnt_r, opCnt_nxt;
  logic        refreshBusy_r;
  logic        odtEnable_r;
  logic        readAllowed_r;
  logic        isIdle_r;
  dcps_cmd_t   cmd;

  // --------------------------------------------------------------
  // Command decode and timers
  // --------------------------------------------------------------
  // Pins sampled on the rising edge by the state register below
  dcps_cmd_decode uDecode (
    .csN  (csN),
    .actN (actN),
    .rasN (rasN),
    .casN (casN),
    .weN  (weN),
    .cmd  (cmd)
  );

  wire logic srExit = (state_r == DCPS_SREF) && !ckePrev_r && cke;
  wire logic pdExit = (state_r == DCPS_PDOWN) && !ckePrev_r && cke;
  wire logic xsDone;
  wire logic xsdllDone;
  wire logic xpDone;

  dcps_timer uXs (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .load    (srExit),
    .loadVal (20'(`DCPS_XS_CYC)),
    .done    (xsDone)
  );

  dcps_timer uXsdll (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .load    (srExit),
    .loadVal (20'(`DCPS_XSDLL_CYC)),
    .done    (xsdllDone)
  );

  dcps_timer uXp (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .load    (pdExit),
    .loadVal (20'(`DCPS_XP_CYC)),
    .done    (xpDone)
  );

  // --------------------------------------------------------------
  // Edge classification
  // --------------------------------------------------------------
  // Clock enable pair picks the action for this edge
  wire logic ckeFall = ckePrev_r && !cke;
  wire logic ckeHold = ckePrev_r && cke;
  wire logic ckeLow  = !ckePrev_r && !cke;
  wire logic opDone  = (opCnt_r == 8'h00);
  // Deselect and no-operation accept nothing new
  wire logic newCmd  = ckeHold && (cmd != DCPS_C_DES) && (cmd != DCPS_C_NOP);

  // Idle: banks closed, no burst, clock enable high, self-refresh and power-down exit timers expired
  // Clock enable counts at the edge before, so a falling edge can still see idle
  wire logic idleNow = (state_r == DCPS_IDLE) && !banksOpen_r && opDone
                       && ckePrev_r && xsDone && xpDone;

  // Where an operation settles, from the bank state it leaves behind
  function automatic dcps_state_t rest_state(input logic open);
    return open ? DCPS_ACTIVE : DCPS_IDLE;
  endfunction

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    banksOpen_nxt = banksOpen_r;
    opCnt_nxt     = opDone ? opCnt_r : opCnt_r - 8'h01;
    case (state_r)
      DCPS_PDOWN: begin
        // Burst with auto precharge still closes its bank on its last cycle
        if (autoPre && opCnt_r == 8'h01)
          banksOpen_nxt = 1'b0;
        // Pins ignored while low; exit on rise
        if (cke)
          state_nxt = rest_state(banksOpen_nxt);
      end
      DCPS_SREF: begin
        opCnt_nxt = 8'h00;
        if (cke)
          state_nxt = DCPS_IDLE;
      end
      DCPS_IDLE: begin
        if (ckeFall && idleNow && cmd == DCPS_C_DES)
          state_nxt = DCPS_SREF;
        else if (ckeFall)
          state_nxt = DCPS_PDOWN;
        else if (newCmd && cmd == DCPS_C_ACT) begin
          banksOpen_nxt = 1'b1;
          state_nxt     = DCPS_ACTIVE;
        end else if (newCmd && cmd == DCPS_C_REF) begin
          opCnt_nxt = `DCPS_REF_CYC;
          state_nxt = DCPS_REFR;
        end
      end
      DCPS_ACTIVE: begin
        if (ckeFall)
          state_nxt = DCPS_PDOWN;
        else if (newCmd && cmd == DCPS_C_RD) begin
          opCnt_nxt = `DCPS_BURST_CYC;
          state_nxt = DCPS_READ;
        end else if (newCmd && cmd == DCPS_C_WR) begin
          opCnt_nxt = `DCPS_BURST_CYC;
          state_nxt = DCPS_WRITE;
        end else if (newCmd && cmd == DCPS_C_PRE) begin
          opCnt_nxt = `DCPS_PRE_CYC;
          state_nxt = DCPS_PRECH;
        end
      end
      DCPS_READ, DCPS_WRITE, DCPS_PRECH: begin
        if (state_r == DCPS_PRECH)
          banksOpen_nxt = 1'b0;
        else if (autoPre && opDone)
          banksOpen_nxt = 1'b0;
        // Power-down kind follows bank state at completion
        if (ckeFall)
          state_nxt = DCPS_PDOWN;
        // Settle from the bank state after this edge
        else if (opDone)
          state_nxt = rest_state(banksOpen_nxt);
      end
      DCPS_REFR: begin
        if (ckeFall || (opDone && !ckeLow))
          state_nxt = ckeFall ? DCPS_PDOWN : DCPS_IDLE;
      end
      default: state_nxt = DCPS_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------
  // Asynchronous reset only; all else on the rising edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= DCPS_IDLE;
      ckePrev_r   <= 1'b0;
      banksOpen_r <= 1'b0;
      opCnt_r     <= 8'h00;
    end else begin
      state_r     <= state_nxt;
      ckePrev_r   <= cke;
      banksOpen_r <= banksOpen_nxt;
      opCnt_r     <= opCnt_nxt;
    end
  end

  // Status flags, registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      refreshBusy_r <= 1'b0;
      odtEnable_r   <= 1'b0;
      readAllowed_r <= 1'b0;
      isIdle_r      <= 1'b0;
    end else begin
      refreshBusy_r <= (state_nxt == DCPS_REFR);
      odtEnable_r   <= odt && (state_nxt != DCPS_SREF) && xsdllDone && !srExit;
      readAllowed_r <= xsdllDone && (state_nxt != DCPS_SREF) && !srExit;
      isIdle_r      <= idleNow;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign devState      = state_r;
  assign inPowerDown   = state_r[`DCPS_ST_PDOWN_BIT];
  assign inSelfRefresh = state_r[`DCPS_ST_SREF_BIT];
  assign banksOpen     = banksOpen_r;
  assign refreshBusy   = refreshBusy_r;
  assign odtEnable     = odtEnable_r;
  assign readAllowed   = readAllowed_r;
  assign isIdle        = isIdle_r;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sref_from_idle_a: assert property (
    (state_r != DCPS_SREF) ##1 (state_r == DCPS_SREF) |-> $past(idleNow))
    else $error("self refresh entered from non-idle");
  no_ref_pdown_a: assert property (
    (state_r == DCPS_PDOWN) |-> !refreshBusy_r)
    else $error("refresh busy in power-down");
  hold_lowpwr_a: assert property (
    (state_r inside {DCPS_PDOWN, DCPS_SREF}) && !cke |=> (state_r == $past(state_r)))
    else $error("low-power state left with clock enable low");
  odt_sref_a: assert property (
    (state_r == DCPS_SREF) |=> !odtEnable_r || (state_r != DCPS_SREF))
    else $error("termination enabled in self refresh");
  nop_noop_a: assert property (
    ckeHold && cmd == DCPS_C_NOP && state_r == DCPS_IDLE |=> state_r == DCPS_IDLE)
    else $error("no-operation changed state");
  des_noop_a: assert property (
    ckeHold && cmd == DCPS_C_DES && state_r == DCPS_ACTIVE |=> state_r == DCPS_ACTIVE)
    else $error("deselect accepted a command");
  burst_runs_a: assert property (
    (state_r == DCPS_READ) && !opDone && ckeHold && cmd == DCPS_C_DES |=> opCnt_r == $past(opCnt_r) - 8'h01)
    else $error("deselect disturbed a burst");
  pd_kind_a: assert property (
    (state_r == DCPS_PDOWN) && cke && !ckePrev_r |=> state_r == (banksOpen_r ? DCPS_ACTIVE : DCPS_IDLE))
    else $error("wrong power-down kind");
  ckepair_a: assert property (
    ckeFall && state_r == DCPS_ACTIVE |=> state_r == DCPS_PDOWN)
    else $error("clock enable fall not acted on");

  // Exit gating, bank closing, timer-driven idle and refresh completion
  lock_wait_a: assert property (
    srExit |=> !readAllowed_r && !odtEnable_r)
    else $error("read or termination allowed at self-refresh exit");
  idle_timers_a: assert property (
    !(xsDone && xpDone) |=> !isIdle_r)
    else $error("idle reported with exit timer running");
  pde_banks_a: assert property (
    (state_r == DCPS_PDOWN) && autoPre && (opCnt_r == 8'h01) |=> !banksOpen_r)
    else $error("bank left open after auto-precharge burst");
  sref_exit_a: assert property (
    (state_r == DCPS_SREF) && cke |=> state_r == DCPS_IDLE)
    else $error("self refresh not left on clock enable rise");
  refr_done_a: assert property (
    (state_r == DCPS_REFR) && opDone && ckeHold |=> state_r == DCPS_IDLE)
    else $error("refresh did not settle to idle");

  sref_c: cover property (state_r == DCPS_IDLE ##1 state_r == DCPS_SREF ##[1:20] state_r == DCPS_IDLE);
  apd_c:  cover property (state_r == DCPS_ACTIVE ##1 state_r == DCPS_PDOWN);
  rd_c:   cover property (state_r == DCPS_READ ##[1:10] state_r == DCPS_ACTIVE);
  ppd_c:  cover property (state_r == DCPS_READ ##1 state_r == DCPS_PDOWN);
  srx_c:  cover property (srExit ##1 !readAllowed_r);

endmodule
`default_nettype wire

//--- dv/dcps_ctrl_model.sv
/*
  Memory controller model driving clock enable and the command pins.
  Assumes requests from the bench change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dcps_ctrl_model
  import dcps_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Requests and filler for don't-care pins
  input  wire dcps_cmd_t  cmdReq,
  input  wire logic       ckeReq,
  input  wire logic [3:0] fillVal,
  // Command pins
  output logic            cke,
  output logic            csN,
  output logic            actN,
  output logic            rasN,
  output logic            casN,
  output logic            weN
);
  logic [3:0] pat;

  // Pin pattern {act, ras, cas, we}; unused pins carry a changing filler
  always_comb begin
    case (cmdReq)
      DCPS_C_NOP: pat = 4'hF;
      DCPS_C_ACT: pat = {1'b0, fillVal[2:0]};
      DCPS_C_RD:  pat = 4'hD;
      DCPS_C_WR:  pat = 4'hC;
      DCPS_C_PRE: pat = 4'hA;
      DCPS_C_REF: pat = 4'h9;
      default:    pat = fillVal;
    endcase
  end

  // Clock enable only moves together with a deselect
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cke <= 1'b0;
      csN <= 1'b1;
    end else begin
      cke <= ckeReq;
      csN <= (cmdReq == DCPS_C_DES) || (ckeReq != cke);
    end
  end

  // Command pins follow the request
  always_ff @(posedge ref_clk) begin
    {actN, rasN, casN, weN} <= pat;
  end
endmodule

`default_nettype wire

//--- dv/dcps_power_ctrl_tb.sv
/*
  Self-checking bench for the clock-enable power-state block.
  Assumes the controller model above and the design's one-hot state codes.
*/
`timescale 1ns/1ps
`default_nettype none

module dcps_power_ctrl_tb
  import dcps_pkg::*;
;
  logic       ref_clk, reset_n, ckeReq, odtFree, autoPre, watchOn;
  dcps_cmd_t  cmdReq;
  logic [7:0] lfsrVal, prevState, devState;
  logic [7:0] expQ[$];
  wire  [3:0] fillVal = lfsrVal[3:0];
  wire        odtPin  = odtFree ? lfsrVal[7] : 1'b1;
  wire        cke, csN, actN, rasN, casN, weN;
  logic       inPowerDown, inSelfRefresh, isIdle, banksOpen, refreshBusy, odtEnable, readAllowed;
  int         err_count, cmp_count;

  dcps_ctrl_model i_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .cmdReq(cmdReq), .ckeReq(ckeReq),
    .fillVal(fillVal), .cke(cke), .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN));

  dcps_power_ctrl i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cke(cke), .csN(csN), .actN(actN),
    .rasN(rasN), .casN(casN), .weN(weN), .odt(odtPin), .autoPre(autoPre), .devState(devState),
    .inPowerDown(inPowerDown), .inSelfRefresh(inSelfRefresh), .isIdle(isIdle), .banksOpen(banksOpen),
    .refreshBusy(refreshBusy), .odtEnable(odtEnable), .readAllowed(readAllowed));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk_flag(input logic got, input logic expv, input string what);
    cmp_count++;
    if (got !== expv) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_state(input logic [7:0] got, input logic [7:0] expv);
    cmp_count++;
    if (got !== expv) begin
      err_count++;
      $display("mismatch at %0t: state %h, expected %h", $time, got, expv);
    end
  endtask

  // One request, then deselects for n cycles
  task automatic step(input dcps_cmd_t c, input logic k, input int n);
    @(posedge ref_clk);
    cmdReq <= c;
    ckeReq <= k;
    @(posedge ref_clk);
    cmdReq <= DCPS_C_DES;
    repeat (n) @(posedge ref_clk);
    // Return off the edge so callers see settled outputs
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Random filler for don't-care pins
  always @(posedge ref_clk) lfsrVal <= lfsr_next(lfsrVal);

  // Each state move while watchOn is set takes the oldest note; a move with no note fails
  always @(posedge ref_clk) begin
    #1;
    if (reset_n && watchOn && devState !== prevState) begin
      if (expQ.size() == 0)
        chk_state(devState, prevState);
      else
        chk_state(devState, expQ.pop_front());
    end
    prevState = devState;
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    cmdReq = DCPS_C_DES;
    ckeReq = 1'b1;
    odtFree = 1'b1;
    autoPre = 1'b0;
    watchOn = 1'b1;
    lfsrVal = 8'h22;
    prevState = 8'h01;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_state(devState, 8'h01);
    step(DCPS_C_NOP, 1, 4);
    step(DCPS_C_DES, 1, 4);
    expQ.push_back(8'h02);
    step(DCPS_C_ACT, 1, 3);
    chk_flag(isIdle, 1'b0, "idle with bank open");
    expQ = {expQ, 8'h04, 8'h02};
    step(DCPS_C_RD, 1, 10);
    expQ = {expQ, 8'h08, 8'h02};
    step(DCPS_C_WR, 1, 10);
    expQ.push_back(8'h40);
    step(DCPS_C_DES, 0, 3);
    chk_flag(inPowerDown, 1'b1, "no power-down");
    chk_flag(banksOpen, 1'b1, "banks lost");
    chk_flag(inSelfRefresh, 1'b0, "self refresh from active");
    step(DCPS_C_ACT, 0, 4);
    step(DCPS_C_REF, 0, 4);
    chk_flag(refreshBusy, 1'b0, "refresh in power-down");
    expQ.push_back(8'h02);
    step(DCPS_C_DES, 1, 4);
    expQ = {expQ, 8'h10, 8'h01};
    step(DCPS_C_PRE, 1, 10);
    expQ = {expQ, 8'h20, 8'h01};
    step(DCPS_C_REF, 1, 20);
    chk_flag(isIdle, 1'b1, "not idle after refresh");
    odtFree <= 1'b0;
    expQ.push_back(8'h80);
    step(DCPS_C_DES, 0, 4);
    chk_flag(inSelfRefresh, 1'b1, "no self refresh");
    chk_flag(odtEnable, 1'b0, "termination in self refresh");
    step(DCPS_C_NOP, 0, 4);
    expQ.push_back(8'h01);
    step(DCPS_C_DES, 1, 2);
    chk_flag(readAllowed, 1'b0, "read before lock");
    chk_flag(odtEnable, 1'b0, "termination before lock");
    repeat (700) @(posedge ref_clk);
    chk_flag(readAllowed, 1'b1, "read after lock");
    chk_flag(odtEnable, 1'b1, "termination after lock");
    watchOn = 1'b0;
    autoPre <= 1'b1;
    step(DCPS_C_ACT, 1, 2);
    step(DCPS_C_RD, 1, 0);
    step(DCPS_C_DES, 0, 20);
    chk_flag(inPowerDown, 1'b1, "no power-down in read");
    chk_flag(banksOpen, 1'b0, "active power-down after precharge");
    step(DCPS_C_DES, 1, 20);
    autoPre <= 1'b0;
    watchOn = 1'b1;
    expQ.push_back(8'h02);
    step(DCPS_C_ACT, 1, 3);
    #5 reset_n = 1'b0;
    #1 chk_state(devState, 8'h01);
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_flag(expQ.size() == 0, 1'b1, "notes left over");
    end_of_test();
  end
endmodule

`default_nettype wire
